// ### pkg/hpmp_pkg.sv
// Constants for the host port and modem pin block.
// Assumes a single 10 MHz clock and a synchronous active-high reset.
package hpmp_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    // Register select values inside a port
    localparam logic [2:0] REG_DATA       = 3'h0;
    localparam logic [2:0] REG_MODEM_CTRL = 3'h4;
    localparam logic [2:0] REG_MODEM_STAT = 3'h6;
    localparam logic [2:0] REG_SCRATCH    = 3'h7;
    // Field positions
    localparam int unsigned MCR_DTR_BIT = 0;
    localparam int unsigned MCR_RTS_BIT = 1;
    localparam int unsigned MSR_CTS_BIT = 4;
    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam int unsigned NUM_REGS = 8;
    typedef enum logic [1:0] {
        HPMP_SEL_NONE,
        HPMP_SEL_SER0,
        HPMP_SEL_SER1,
        HPMP_SEL_PAR
    } hpmp_sel_t;
endpackage

// ### src/hpmp_top.sv
// Host register port with modem handshake pins for two serial channels
// and a parallel port register bank.
// Assumes strobes, selects and modem inputs come from pins in another domain.
`timescale 1ns/1ps

// Behaviour
// - Each channel's terminal-ready output equals bit 0 of its modem control register.
// - Each channel's request-to-send output equals bit 1 of its modem control register.
// - Each channel's modem status bit 4 shows its clear-to-send input.
// - Host data line 0 is the least significant bit of every register.
// - The data lines are driven only while returning read data and released otherwise.
// - The register select lines choose the register inside the selected port.
// - While the write strobe is asserted the data lines are stored once into the chosen register.
// - While the read strobe is asserted the chosen register is placed on the data lines.
// - Serial channel 0 registers are accessed only while its select is asserted.
// - Serial channel 1 registers are accessed only while its select is asserted.
// - Parallel port registers are accessed only while its select is asserted.
module hpmp_top
    import hpmp_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    // Host bus
    input  wire logic [7:0] host_data_lines_i,
    output logic      [7:0] host_data_lines_o,
    output logic      [7:0] host_data_lines_oe_n_o,
    input  wire logic [2:0] register_select_lines_i,
    input  wire logic       host_write_strobe_i,
    input  wire logic       host_read_strobe_i,
    input  wire logic       serial_channel0_select_i,
    input  wire logic       serial_channel1_select_i,
    input  wire logic       parallel_port_select_i,
    // Modem pins
    input  wire logic [1:0] clear_to_send_i,
    output logic      [1:0] data_terminal_ready_o,
    output logic      [1:0] request_to_send_o
);

    localparam int unsigned NCTL = 5;

    // Three-stage synchronisers; a change counts when stages 2 and 3 agree
    logic [NCTL-1:0] ctl_s1_r;
    logic [NCTL-1:0] ctl_s2_r;
    logic [NCTL-1:0] ctl_s3_r;
    logic [NCTL-1:0] ctl_r;
    logic [1:0]      cts_s1_r;
    logic [1:0]      cts_s2_r;
    logic [1:0]      cts_s3_r;
    logic [1:0]      cts_r;
    logic [2:0]      addr_r;
    logic [7:0]      wdat_r;
    logic [7:0]      ser0_r [NUM_REGS];
    logic [7:0]      ser1_r [NUM_REGS];
    logic [7:0]      par_r  [NUM_REGS];
    logic [7:0]      rdat_r;
    logic            rd_act_r;
    logic            wr_done_r;
    hpmp_sel_t       sel;
    logic            wr_go;
    logic            rd_go;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ctl_s1_r <= '0;
            ctl_s2_r <= '0;
            ctl_s3_r <= '0;
            ctl_r    <= '0;
            cts_s1_r <= '0;
            cts_s2_r <= '0;
            cts_s3_r <= '0;
            cts_r    <= '0;
        end else begin
            ctl_s1_r <= {parallel_port_select_i, serial_channel1_select_i,
                         serial_channel0_select_i, host_read_strobe_i, host_write_strobe_i};
            ctl_s2_r <= ctl_s1_r;
            ctl_s3_r <= ctl_s2_r;
            for (int i = 0; i < NCTL; i++) begin
                if (ctl_s2_r[i] == ctl_s3_r[i]) begin
                    ctl_r[i] <= ctl_s3_r[i];
                end
            end
            cts_s1_r <= clear_to_send_i;
            cts_s2_r <= cts_s1_r;
            cts_s3_r <= cts_s2_r;
            for (int i = 0; i < 2; i++) begin
                if (cts_s2_r[i] == cts_s3_r[i]) begin
                    cts_r[i] <= cts_s3_r[i];
                end
            end
        end
    end

    // Address and data are registered every cycle without synchronisers; host holds them steady
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            addr_r <= '0;
            wdat_r <= '0;
        end else begin
            addr_r <= register_select_lines_i;
            wdat_r <= host_data_lines_i;
        end
    end

    // Exactly one select steers the access; anything else is ignored
    always_comb begin
        unique case (ctl_r[4:2])
            3'b001:  sel = HPMP_SEL_SER0;
            3'b010:  sel = HPMP_SEL_SER1;
            3'b100:  sel = HPMP_SEL_PAR;
            default: sel = HPMP_SEL_NONE;
        endcase
    end

    assign wr_go = ctl_r[0] && !wr_done_r && (sel != HPMP_SEL_NONE);
    assign rd_go = ctl_r[1] && (sel != HPMP_SEL_NONE);

    // One store per strobe assertion, so a long strobe writes the same value once
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wr_done_r <= 1'b0;
        end else begin
            wr_done_r <= ctl_r[0] && (wr_done_r || wr_go);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                ser0_r[i] <= RST_REG;
                ser1_r[i] <= RST_REG;
                par_r[i]  <= RST_REG;
            end
        end else if (wr_go) begin
            unique case (sel)
                HPMP_SEL_SER0: ser0_r[addr_r] <= wdat_r;
                HPMP_SEL_SER1: ser1_r[addr_r] <= wdat_r;
                HPMP_SEL_PAR:  par_r[addr_r]  <= wdat_r;
                HPMP_SEL_NONE: ;
            endcase
        end
    end

    // Read path; the modem status word carries the live clear-to-send level
    function automatic logic [7:0] ser_read(input logic [7:0] regv, input logic [2:0] a,
                                            input logic cts);
        logic [7:0] v;
        v = regv;
        if (a == REG_MODEM_STAT) begin
            v[MSR_CTS_BIT] = cts;
        end
        return v;
    endfunction

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rdat_r   <= RST_REG;
            rd_act_r <= 1'b0;
        end else begin
            rd_act_r <= rd_go;
            unique case (sel)
                HPMP_SEL_SER0: rdat_r <= ser_read(ser0_r[addr_r], addr_r, cts_r[0]);
                HPMP_SEL_SER1: rdat_r <= ser_read(ser1_r[addr_r], addr_r, cts_r[1]);
                HPMP_SEL_PAR:  rdat_r <= par_r[addr_r];
                HPMP_SEL_NONE: rdat_r <= rdat_r;
            endcase
        end
    end

    assign host_data_lines_o      = rdat_r;
    assign host_data_lines_oe_n_o = {8{!rd_act_r}};
    assign data_terminal_ready_o  = {ser1_r[REG_MODEM_CTRL][MCR_DTR_BIT],
                                     ser0_r[REG_MODEM_CTRL][MCR_DTR_BIT]};
    assign request_to_send_o      = {ser1_r[REG_MODEM_CTRL][MCR_RTS_BIT],
                                     ser0_r[REG_MODEM_CTRL][MCR_RTS_BIT]};

    // Checked against the written byte, not the register bit the pin is wired from
    property p_dtr0;
        @(posedge mclk_i) disable iff (reset_i)
        (wr_go && sel == HPMP_SEL_SER0 && addr_r == REG_MODEM_CTRL)
            |=> data_terminal_ready_o[0] == $past(wdat_r[MCR_DTR_BIT]);
    endproperty
    a_dtr0: assert property (p_dtr0) else $error("dtr0 mismatch");

    property p_rts1;
        @(posedge mclk_i) disable iff (reset_i)
        (wr_go && sel == HPMP_SEL_SER1 && addr_r == REG_MODEM_CTRL)
            |=> request_to_send_o[1] == $past(wdat_r[MCR_RTS_BIT]);
    endproperty
    a_rts1: assert property (p_rts1) else $error("rts1 mismatch");

    property p_cts;
        @(posedge mclk_i) disable iff (reset_i)
        (rd_go && sel == HPMP_SEL_SER0 && addr_r == REG_MODEM_STAT)
            |=> rdat_r[MSR_CTS_BIT] == $past(cts_r[0]);
    endproperty
    a_cts: assert property (p_cts) else $error("cts not in status");

    property p_oe;
        @(posedge mclk_i) disable iff (reset_i)
        !$past(rd_go) |-> host_data_lines_oe_n_o == 8'hff;
    endproperty
    a_oe: assert property (p_oe) else $error("bus driven without read");

    property p_wr;
        @(posedge mclk_i) disable iff (reset_i)
        (wr_go && sel == HPMP_SEL_SER1) |=> ser1_r[$past(addr_r)] == $past(wdat_r);
    endproperty
    a_wr: assert property (p_wr) else $error("write not stored");

    property p_rd;
        @(posedge mclk_i) disable iff (reset_i)
        rd_go |=> !host_data_lines_oe_n_o[0];
    endproperty
    a_rd: assert property (p_rd) else $error("read not driven");

    property p_nosel;
        @(posedge mclk_i) disable iff (reset_i)
        (sel == HPMP_SEL_NONE) |=> $stable(par_r[0]) && $stable(ser0_r[4]) && !rd_act_r;
    endproperty
    a_nosel: assert property (p_nosel) else $error("access without select");

    property p_par;
        @(posedge mclk_i) disable iff (reset_i)
        (sel != HPMP_SEL_PAR) |=> $stable(par_r[7]);
    endproperty
    a_par: assert property (p_par) else $error("parallel reg changed unselected");

endmodule

// ### test/hpmp_host_model.sv
// Host bus model: three chip select lines as given by the caller, strobes, address and data lines.
// Assumes one caller of xfer at a time and a device with registered reads.
`timescale 1ns/1ps
module hpmp_host_model (
    // Clock
    input  wire logic       mclk_i,
    // Device read side
    input  wire logic [7:0] dev_data_i,
    input  wire logic [7:0] dev_oe_n_i,
    // Host drive
    output logic      [7:0] data_o,
    output logic      [2:0] addr_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [2:0] cs_o
);
    logic       drive_r = 1'b0;
    logic [7:0] wdata_r = 8'h00;
    logic [7:0] last_r  = 8'h00;
    initial begin
        addr_o = 3'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        cs_o = 3'h0;
    end
    // Undriven lines toggle so a stale value never reads as valid data
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            data_o[b] = drive_r ? wdata_r[b] : (!dev_oe_n_i[b] ? dev_data_i[b] : ~last_r[b]);
        end
    end
    always_ff @(posedge mclk_i) begin
        last_r <= data_o;
    end
    task automatic xfer(input logic [2:0] cs, input logic [2:0] a, input logic wr,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk_i);
        cs_o    <= cs;
        addr_o  <= a;
        wdata_r <= d;
        drive_r <= wr;
        wr_o    <= wr;
        rd_o    <= !wr;
        for (int k = 0; k < 12; k++) begin
            @(posedge mclk_i);
            if (!wr && dev_oe_n_i === 8'h00) break;
        end
        @(posedge mclk_i);
        // Read data counts only if the device really drives the lines
        q = (dev_oe_n_i === 8'h00) ? data_o : 8'hxx;
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        // Select, address and data outlive the strobe through the synchronisers
        repeat (6) @(posedge mclk_i);
        cs_o    <= 3'h0;
        drive_r <= 1'b0;
        repeat (6) @(posedge mclk_i);
    endtask
endmodule

// ### test/hpmp_top_bench.sv
// Self-checking bench for hpmp_top driven through the host bus model.
// Assumes the 10 MHz clock and synchronous active-high reset of the package.
`timescale 1ns/1ps
module hpmp_top_bench;
    import hpmp_pkg::*;
    logic       mclk  = 1'b0;
    logic       reset = 1'b1;
    logic [1:0] cts   = 2'b00;
    logic [7:0] hd_i, hd_o, oe_n, q;
    logic [2:0] addr, cs;
    logic       wr, rd;
    logic [1:0] dtr, rts;
    int         failures = 0;
    int         n_checks = 0;
    int         n_drive  = 0;
    hpmp_top hpmp_top_inst (.mclk_i(mclk), .reset_i(reset), .host_data_lines_i(hd_i),
        .host_data_lines_o(hd_o), .host_data_lines_oe_n_o(oe_n),
        .register_select_lines_i(addr), .host_write_strobe_i(wr), .host_read_strobe_i(rd),
        .serial_channel0_select_i(cs[0]), .serial_channel1_select_i(cs[1]),
        .parallel_port_select_i(cs[2]), .clear_to_send_i(cts),
        .data_terminal_ready_o(dtr), .request_to_send_o(rts));
    hpmp_host_model hpmp_host_model_inst (.mclk_i(mclk), .dev_data_i(hd_o),
        .dev_oe_n_i(oe_n), .data_o(hd_i), .addr_o(addr), .wr_o(wr), .rd_o(rd), .cs_o(cs));
    initial begin
        forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
    end
    // Counts every cycle in which the device drives the data lines
    always @(posedge mclk) begin
        if (oe_n !== 8'hff) begin
            n_drive <= n_drive + 1;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr8(input logic [2:0] c, input logic [2:0] a, input logic [7:0] d);
        hpmp_host_model_inst.xfer(c, a, 1'b1, d, q);
    endtask
    task automatic rd8(input logic [2:0] c, input logic [2:0] a);
        hpmp_host_model_inst.xfer(c, a, 1'b0, 8'h00, q);
    endtask
    task automatic t_ports();
        for (int p = 0; p < 3; p++) begin
            wr8(3'h1 << p, REG_SCRATCH, 8'h01 << (p * 3));
            wr8(3'h1 << p, REG_DATA, 8'hf0);
        end
        for (int p = 0; p < 3; p++) begin
            rd8(3'h1 << p, REG_SCRATCH);
            check(q, 8'h01 << (p * 3));
        end
        rd8(3'h4, REG_DATA);
        check(q, 8'hf0);
        check(oe_n, 8'hff);
        $display("test ports done");
    endtask
    task automatic t_modem();
        logic [1:0] u, w;
        for (int v = 0; v < 4; v++) begin
            u = 2'(v);
            w = 2'(3 - v);
            wr8(3'h1, REG_MODEM_CTRL, {6'h00, u});
            wr8(3'h2, REG_MODEM_CTRL, {6'h00, w});
            check({6'h00, dtr}, {6'h00, w[0], u[0]});
            check({6'h00, rts}, {6'h00, w[1], u[1]});
        end
        $display("test modem done");
    endtask
    task automatic t_cts();
        for (int c = 1; c < 3; c++) begin
            @(posedge mclk);
            cts <= 2'(c);
            repeat (4) @(posedge mclk);
            rd8(3'h1, REG_MODEM_STAT);
            check(q, {3'h0, cts[0], 4'h0});
            rd8(3'h2, REG_MODEM_STAT);
            check(q, {3'h0, cts[1], 4'h0});
        end
        $display("test cts done");
    endtask
    task automatic t_refuse();
        int d0;
        d0 = n_drive;
        rd8(3'h0, REG_SCRATCH);
        check(8'(n_drive - d0), 8'h00);
        wr8(3'h0, REG_SCRATCH, 8'hee);
        wr8(3'h3, REG_SCRATCH, 8'hee);
        rd8(3'h1, REG_SCRATCH);
        check(q, 8'h01);
        rd8(3'h2, REG_SCRATCH);
        check(q, 8'h08);
        $display("test refuse done");
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        check(oe_n, 8'hff);
        check({4'h0, dtr, rts}, 8'h00);
        $display("test reset done");
        t_ports();
        t_modem();
        t_cts();
        t_refuse();
        summarize();
    end
    // About 30 transfers of 20 to 26 cycles each; generous margin
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        summarize();
    end
endmodule
